// ---- rtl/stm_timer.sv ----
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: sixteen-bit up counter on selected clock
// RL2: compare P checks counter top byte only
// RL3: compare A checks all sixteen bits
// RL4: counter cleared by run rising edge, match or overflow
// RL5: overflow or match clears counter, raises flag
// RL6: pause holds count, resumes from it
// RL7: three-bit field picks counter clock source
// RL8: run low stops counter, value kept
// RL9: run rising edge loads initial pin level
// RL10: two-bit field selects operating mode
// RL11: software stops timer before mode change
// RL12: timer mode leaves pin function unused
// RL13: compare mode A match: none/low/high/toggle
// RL14: pwm mode: inactive/active/pwm/single pulse
// RL15: same-level request gives no pin change
// RL16: software changes pwm function only stopped
// RL17: control zero low three bits read zero
// RL18: initial bit sets start or active level
// RL19: polarity bit inverts pin, not timer mode
// RL20: swap bit exchanges period and duty roles
// RL21: count per tick when running, not paused
// RL22: sticky flag per comparator, software clears
module stm_timer
   import stm_pkg::*;
(
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset, high
   input wire logic [4:0] adr_i, // wishbone byte address
   input wire logic [31:0] dat_i, // write data
   output logic [31:0] dat_o, // read data
   input wire logic we_i, // write enable
   input wire logic [3:0] sel_i, // byte lanes
   input wire logic cyc_i, // bus cycle
   input wire logic stb_i, // strobe
   output logic ack_o, // acknowledge
   input wire logic ext_clk_i, // external_clock_pin
   output logic pin_o, // timer_output_pin level
   output logic pin_oe_o // high while mode drives the pin
);
   logic [7:0] ctrl0;
   logic [7:0] ctrl1;
   logic [15:0] count;
   logic [15:0] cmp_a;
   logic [7:0] cmp_p;
   logic [1:0] flags;
   logic out_lvl;
   logic run_q;
   logic ack;
   logic [31:0] rdata;
   stm_sp_e sp_st;
   logic [7:0] next_ctrl0;
   logic [7:0] next_ctrl1;
   logic [15:0] next_count;
   logic [15:0] next_cmp_a;
   logic [7:0] next_cmp_p;
   logic [1:0] next_flags;
   logic next_out_lvl;
   logic next_ack;
   logic [31:0] next_rdata;
   stm_sp_e next_sp_st;
   logic tick;
   logic run;
   logic run_rise;
   logic pause;
   stm_mode_e mode;
   logic [1:0] iofn;
   logic init_lvl;
   logic cclr;
   logic dpx;
   logic match_a;
   logic match_p;
   logic ovf;
   logic clr;
   logic set_a;
   logic set_p;
   logic wr;
   logic rd;
   logic wr0;
   logic [15:0] period_end;
   logic pwm_active;
   logic raw_pin;

   assign run = ctrl0[STM_C0_RUN];
   assign pause = ctrl0[STM_C0_PAUSE];
   assign mode = stm_mode_e'(ctrl1[STM_C1_MODE_HI:STM_C1_MODE_LO]);
   assign iofn = ctrl1[STM_C1_IO_HI:STM_C1_IO_LO];
   assign init_lvl = ctrl1[STM_C1_INIT];
   assign cclr = ctrl1[STM_C1_CCLR];
   assign dpx = ctrl1[STM_C1_DPX];
   assign run_rise = run & ~run_q;
   assign wr = cyc_i & stb_i & we_i & ~ack;
   assign rd = cyc_i & stb_i & ~we_i & ~ack;
   assign wr0 = wr & sel_i[0];

   // counter clock selection
   stm_tick_gen u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(ctrl0[STM_C0_CKS_HI:STM_C0_CKS_LO]),
      .ext_i(ext_clk_i),
      .tick_o(tick)
   );

   // comparators: match seen on the tick that leaves the matching value
   always_comb begin
      match_a = tick && run && !pause && (count == cmp_a); // RL3 RL21
      // a zero compare P spans the full range, so it may only match at overflow
      match_p = tick && run && !pause && ((cmp_p == STM_RESET_BYTE) ? (count == STM_CNT_MAX)
                : ((count[15:8] == cmp_p) && (count[7:0] == STM_CNT_MAX[7:0]))); // RL2
      ovf = tick && run && !pause && (count == STM_CNT_MAX);
   end

   // clear source: pwm uses the period register, else the clear-select bit
   always_comb begin
      if (mode == STM_MODE_PWM) begin
         clr = dpx ? match_a : match_p; // RL20
      end else begin
         clr = cclr ? match_a : match_p; // RL5
      end
      clr = clr | ovf; // RL5
      // a zero compare A never flags; with clear on A (cclr) outside pwm, P flag suppressed
      set_a = match_a && (cmp_a != 16'h0000);
      set_p = match_p && !(cclr && (mode != STM_MODE_PWM));
      if (cmp_p == STM_RESET_BYTE) begin
         set_p = set_p & ovf;
      end
   end

   // counter next value; no software write path to it
   always_comb begin
      next_count = count;
      if (run_rise) begin
         next_count = 16'h0000; // RL4
      end else if (run && !pause && tick) begin // RL6 RL8 RL21
         if (clr) begin
            next_count = 16'h0000; // RL5
         end else begin
            next_count = count + 16'h0001; // RL1
         end
      end
   end

   // pwm duty compare, full duty when duty exceeds the period
   always_comb begin
      period_end = dpx ? cmp_a : {cmp_p, STM_CNT_MAX[7:0]};
      if (dpx) begin
         pwm_active = ({cmp_p, 8'h00} > count) || ({cmp_p, 8'h00} > period_end); // RL20
      end else begin
         pwm_active = (cmp_a > count) || (cmp_a > period_end); // RL20
      end
   end

   // pin level and single pulse sequencer
   always_comb begin
      next_out_lvl = out_lvl;
      next_sp_st = sp_st;
      if (run_rise) begin
         next_out_lvl = init_lvl; // RL9 RL18
         next_sp_st = (iofn == 2'h3) ? STM_SP_PULSE : STM_SP_IDLE;
      end else begin
         case (mode) // RL10
            STM_MODE_CMP: begin
               if (set_a) begin
                  case (iofn) // RL13 RL15
                     2'h1: next_out_lvl = 1'b0;
                     2'h2: next_out_lvl = 1'b1;
                     2'h3: next_out_lvl = ~out_lvl;
                     default: next_out_lvl = out_lvl;
                  endcase
               end
            end
            STM_MODE_PWM: begin
               case (iofn) // RL14
                  2'h0: next_out_lvl = ~init_lvl;
                  2'h1: next_out_lvl = init_lvl;
                  2'h2: next_out_lvl = pwm_active ? init_lvl : ~init_lvl; // RL18
                  default: begin
                     // one active pulse ending at the compare A match
                     case (sp_st)
                        STM_SP_PULSE: begin
                           next_out_lvl = init_lvl;
                           if (match_a) begin
                              next_sp_st = STM_SP_DONE;
                           end
                        end
                        STM_SP_DONE: next_out_lvl = ~init_lvl;
                        default: next_out_lvl = ~init_lvl;
                     endcase
                  end
               endcase
            end
            default: next_out_lvl = out_lvl; // RL12
         endcase
      end
   end

   // pin drive: polarity only where the pin is in use
   always_comb begin
      raw_pin = out_lvl ^ ctrl1[STM_C1_POL]; // RL19
      pin_oe_o = (mode == STM_MODE_CMP) || (mode == STM_MODE_PWM); // RL12
      pin_o = pin_oe_o ? raw_pin : 1'b0;
   end

   // register writes, flag set wins over a write-one clear
   always_comb begin
      next_ctrl0 = ctrl0;
      next_ctrl1 = ctrl1;
      next_cmp_a = cmp_a;
      next_cmp_p = cmp_p;
      next_flags = flags;
      if (wr0) begin
         case (adr_i)
            STM_ADDR_CTRL0: next_ctrl0 = dat_i[7:0] & STM_C0_MASK; // RL17
            STM_ADDR_CTRL1: next_ctrl1 = dat_i[7:0]; // taken as is, even while running
            STM_ADDR_CMPAL: next_cmp_a[7:0] = dat_i[7:0];
            STM_ADDR_CMPAH: next_cmp_a[15:8] = dat_i[7:0];
            STM_ADDR_CMPP: next_cmp_p = dat_i[7:0];
            STM_ADDR_FLAGS: next_flags = flags & ~dat_i[1:0];
            default: next_flags = flags;
         endcase
      end
      if (set_a) begin
         next_flags[STM_FLAG_A] = 1'b1; // RL22
      end
      if (set_p) begin
         next_flags[STM_FLAG_P] = 1'b1; // RL22
      end
   end

   // read mux; unmapped addresses read zero and still ack
   always_comb begin
      next_ack = cyc_i & stb_i & ~ack;
      next_rdata = 32'h0000_0000;
      if (rd) begin
         case (adr_i)
            STM_ADDR_CTRL0: next_rdata = {24'h000000, ctrl0 & STM_C0_MASK}; // RL17
            STM_ADDR_CTRL1: next_rdata = {24'h000000, ctrl1};
            STM_ADDR_CNTL: next_rdata = {24'h000000, count[7:0]};
            STM_ADDR_CNTH: next_rdata = {24'h000000, count[15:8]};
            STM_ADDR_CMPAL: next_rdata = {24'h000000, cmp_a[7:0]};
            STM_ADDR_CMPAH: next_rdata = {24'h000000, cmp_a[15:8]};
            STM_ADDR_CMPP: next_rdata = {24'h000000, cmp_p};
            STM_ADDR_FLAGS: next_rdata = {30'h00000000, flags};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   assign ack_o = ack;
   assign dat_o = rdata;

   // state registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl0 <= STM_RESET_BYTE;
         ctrl1 <= STM_RESET_BYTE;
         count <= 16'h0000;
         cmp_a <= 16'h0000;
         cmp_p <= STM_RESET_BYTE;
         flags <= 2'b00;
         out_lvl <= 1'b0;
         run_q <= 1'b0;
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
         sp_st <= STM_SP_IDLE;
      end else begin
         ctrl0 <= next_ctrl0;
         ctrl1 <= next_ctrl1;
         count <= next_count;
         cmp_a <= next_cmp_a;
         cmp_p <= next_cmp_p;
         flags <= next_flags;
         out_lvl <= next_out_lvl;
         run_q <= run;
         ack <= next_ack;
         rdata <= next_rdata;
         sp_st <= next_sp_st;
      end
   end

   // checks
   run_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
      run_rise |=> (count == 16'h0000)) else $error("count not cleared on run");
   stop_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
      (!run && run_q == run) |=> $stable(count)) else $error("count moved while off");
   pause_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
      (pause && !run_rise) |=> $stable(count)) else $error("count moved while paused");
   count_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
      (run && !pause && tick && !clr && !run_rise) |=> (count == $past(count) + 16'h0001))
      else $error("count did not step");
   flag_a_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL22
      set_a |=> flags[STM_FLAG_A]) else $error("flag a lost");
   flag_p_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL22
      set_p |=> flags[STM_FLAG_P]) else $error("flag p lost");
   init_level_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
      run_rise |=> (out_lvl == $past(init_lvl))) else $error("pin init wrong");
   low_bits_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
      ctrl0[2:0] == 3'h0) else $error("low control bits set");
   bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) // bus access, implementer's choice
      (cyc_i && stb_i && !ack) |=> ack) else $error("no ack");
   clr_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
      (clr && run && !pause && !run_rise) |=> (count == 16'h0000))
      else $error("clear missed");
   cov_match_a: cover property (@(posedge clk_i) disable iff (rst_i) set_a);
   cov_match_p: cover property (@(posedge clk_i) disable iff (rst_i) set_p);
   cov_ovf: cover property (@(posedge clk_i) disable iff (rst_i) ovf);
   cov_pwm: cover property (@(posedge clk_i) disable iff (rst_i)
      (mode == STM_MODE_PWM) && $rose(out_lvl));
endmodule : stm_timer

// ---- rtl/stm_pkg.sv ----
package stm_pkg;
   // register word addresses on the wishbone bus (byte addresses, one word each)
   localparam logic [4:0] STM_ADDR_CTRL0 = 5'h00;
   localparam logic [4:0] STM_ADDR_CTRL1 = 5'h04;
   localparam logic [4:0] STM_ADDR_CNTL = 5'h08;
   localparam logic [4:0] STM_ADDR_CNTH = 5'h0C;
   localparam logic [4:0] STM_ADDR_CMPAL = 5'h10;
   localparam logic [4:0] STM_ADDR_CMPAH = 5'h14;
   localparam logic [4:0] STM_ADDR_CMPP = 5'h18;
   localparam logic [4:0] STM_ADDR_FLAGS = 5'h1C;
   // control 0 field positions
   localparam int STM_C0_PAUSE = 7;
   localparam int STM_C0_CKS_HI = 6;
   localparam int STM_C0_CKS_LO = 4;
   localparam int STM_C0_RUN = 3;
   localparam logic [7:0] STM_C0_MASK = 8'hF8;
   // control 1 field positions
   localparam int STM_C1_MODE_HI = 7;
   localparam int STM_C1_MODE_LO = 6;
   localparam int STM_C1_IO_HI = 5;
   localparam int STM_C1_IO_LO = 4;
   localparam int STM_C1_INIT = 3;
   localparam int STM_C1_POL = 2;
   localparam int STM_C1_DPX = 1;
   localparam int STM_C1_CCLR = 0;
   // flag register bits
   localparam int STM_FLAG_A = 0;
   localparam int STM_FLAG_P = 1;
   localparam logic [7:0] STM_RESET_BYTE = 8'h00;
   // clock divider ratios (system clock based)
   localparam logic [5:0] STM_DIV_SYS4 = 6'h03;
   localparam logic [5:0] STM_DIV_H16 = 6'h0F;
   localparam logic [5:0] STM_DIV_H64 = 6'h3F;
   // sub clock divider, arbitrary stand-in ratio
   localparam int STM_SUB_DIV = 762;
   localparam logic [15:0] STM_CNT_MAX = 16'hFFFF;

   typedef enum logic [2:0] {
      STM_CK_SYS4 = 3'h0,
      STM_CK_SYS = 3'h1,
      STM_CK_H16 = 3'h2,
      STM_CK_H64 = 3'h3,
      STM_CK_SUB0 = 3'h4,
      STM_CK_SUB1 = 3'h5,
      STM_CK_EXTR = 3'h6,
      STM_CK_EXTF = 3'h7
   } stm_clk_e;

   typedef enum logic [1:0] {
      STM_MODE_CMP = 2'h0,
      STM_MODE_UNDEF = 2'h1,
      STM_MODE_PWM = 2'h2,
      STM_MODE_TMR = 2'h3
   } stm_mode_e;

   // single pulse sequencer, gray coded along idle, pulse, done
   typedef enum logic [1:0] {
      STM_SP_IDLE = 2'b00,
      STM_SP_PULSE = 2'b01,
      STM_SP_DONE = 2'b11
   } stm_sp_e;
endpackage : stm_pkg

// ---- rtl/stm_tick_gen.sv ----
`timescale 1ns/1ps
// counter clock selection: produces one-cycle enable pulses
module stm_tick_gen
   import stm_pkg::*;
(
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset, high
   input wire logic [2:0] sel_i, // clock source select
   input wire logic ext_i, // external clock pin
   output logic tick_o // one-cycle count enable
);
   logic [5:0] div;
   logic [9:0] sub_cnt;
   logic sub_tick;
   logic ext_q;
   logic [5:0] next_div;
   logic [9:0] next_sub_cnt;

   // free-running prescalers
   always_comb begin
      next_div = div + 6'h01;
      next_sub_cnt = (sub_cnt == 10'(STM_SUB_DIV - 1)) ? 10'h000 : sub_cnt + 10'h001;
   end

   assign sub_tick = (sub_cnt == 10'(STM_SUB_DIV - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div <= 6'h00;
         sub_cnt <= 10'h000;
         ext_q <= 1'b0;
      end else begin
         div <= next_div;
         sub_cnt <= next_sub_cnt;
         ext_q <= ext_i;
      end
   end

   // source mux; pin taken as synchronous, edge found against last sample
   always_comb begin
      case (stm_clk_e'(sel_i)) // RL7
         STM_CK_SYS4: tick_o = ((div & STM_DIV_SYS4) == STM_DIV_SYS4);
         STM_CK_SYS: tick_o = 1'b1;
         STM_CK_H16: tick_o = ((div & STM_DIV_H16) == STM_DIV_H16);
         STM_CK_H64: tick_o = (div == STM_DIV_H64);
         STM_CK_SUB0, STM_CK_SUB1: tick_o = sub_tick;
         STM_CK_EXTR: tick_o = ext_i & ~ext_q;
         STM_CK_EXTF: tick_o = ~ext_i & ext_q;
         default: tick_o = 1'b0;
      endcase
   end
endmodule : stm_tick_gen

// ---- testbench/stm_timer_tb_top.sv ----
`timescale 1ns/1ps
module stm_timer_tb_top
   import stm_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] adr = 5'h00;
   logic [31:0] dat_w = 32'h0;
   logic [31:0] dat_r;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic ack_o;
   logic ext = 1'b0;
   logic pin_o;
   logic pin_oe_o;
   int errors = 0;
   int checked = 0;
   logic [7:0] rd;
   logic [7:0] lo;
   logic [7:0] hi;
   int div [6] = '{4, 1, 16, 64, STM_SUB_DIV, STM_SUB_DIV};
   logic [7:0] cfg [8] = '{8'h20, 8'h18, 8'h30, 8'h38, 8'h00, 8'h28, 8'h1C, 8'h98};
   logic pb [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   logic pa [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

   // 25 MHz system clock
   always #20 clk_i = ~clk_i;

   stm_timer stm_timer_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .adr_i(adr),
      .dat_i(dat_w),
      .dat_o(dat_r),
      .we_i(we),
      .sel_i(sel),
      .cyc_i(cyc),
      .stb_i(stb),
      .ack_o(ack_o),
      .ext_clk_i(ext),
      .pin_o(pin_o),
      .pin_oe_o(pin_oe_o)
   );

   task automatic tally_and_finish;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= {24'h0, d};
      sel <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      r = dat_r[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         errors++;
         $display("BAD ack wait expected 1 seen timeout");
         tally_and_finish();
      end
   endtask : wb

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] r;
      wb(1'b1, a, d, 4'h1, r);
   endtask : wr

   task automatic rdb(input logic [4:0] a, output logic [7:0] r);
      wb(1'b0, a, 8'h00, 4'h1, r);
   endtask : rdb

   // pin edges spaced wide enough for the last-sample edge detect
   task automatic pulse(input int k);
      repeat (k) begin
         @(posedge clk_i);
         ext <= 1'b1;
         repeat (4) @(posedge clk_i);
         ext <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask : pulse

   task automatic rd_cnt;
      rdb(STM_ADDR_CNTL, lo);
      rdb(STM_ADDR_CNTH, hi);
   endtask : rd_cnt

   initial begin
      #4000000;
      errors++;
      $display("BAD run length expected end seen hang");
      tally_and_finish();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdb(STM_ADDR_CTRL0, rd);
      chk("ctrl0 reset", rd, 8'h00);
      rdb(STM_ADDR_CTRL1, rd);
      chk("ctrl1 reset", rd, 8'h00);
      chk("oe reset", pin_oe_o, 1'b1);
      // low three bits of control 0 are not kept
      wr(STM_ADDR_CTRL0, 8'h07);
      rdb(STM_ADDR_CTRL0, rd);
      chk("ctrl0 low bits", rd, 8'h00);
      wr(STM_ADDR_CTRL1, 8'hA5);
      rdb(STM_ADDR_CTRL1, rd);
      chk("ctrl1 rw", rd, 8'hA5);
      wb(1'b1, STM_ADDR_CTRL1, 8'h5A, 4'h0, rd);
      rdb(STM_ADDR_CTRL1, rd);
      chk("lane off write", rd, 8'hA5);
      wb(1'b0, 5'h02, 8'h00, 4'h1, rd);
      chk("unmapped read", rd, 8'h00);
      wr(STM_ADDR_CMPP, 8'h3C);
      rdb(STM_ADDR_CMPP, rd);
      chk("cmpp rw", rd, 8'h3C);
      wr(STM_ADDR_CMPP, 8'h00);
      wr(STM_ADDR_CMPAH, 8'h00);
      // software cannot load the counter
      wr(STM_ADDR_CNTL, 8'h55);
      rd_cnt();
      chk("count no write", {hi, lo}, 16'h0000);
      // timer mode, edge sources, pause, stop and restart
      wr(STM_ADDR_CTRL1, 8'hC0);
      chk("oe timer", pin_oe_o, 1'b0);
      wr(STM_ADDR_CTRL0, 8'h68);
      pulse(5);
      rd_cnt();
      chk("count rise", {hi, lo}, 16'h0005);
      wr(STM_ADDR_CTRL0, 8'h78);
      pulse(3);
      rd_cnt();
      chk("count fall", {hi, lo}, 16'h0008);
      wr(STM_ADDR_CTRL0, 8'hF8);
      pulse(2);
      rd_cnt();
      chk("count paused", {hi, lo}, 16'h0008);
      wr(STM_ADDR_CTRL0, 8'h78);
      pulse(1);
      rd_cnt();
      chk("count resumed", {hi, lo}, 16'h0009);
      wr(STM_ADDR_CTRL0, 8'h70);
      pulse(2);
      rd_cnt();
      chk("count stopped", {hi, lo}, 16'h0009);
      wr(STM_ADDR_CTRL0, 8'h78);
      rd_cnt();
      chk("count restart", {hi, lo}, 16'h0000);
      // internal sources: rate within a small margin of the ratio
      for (int s = 0; s < 6; s++) begin
         wr(STM_ADDR_CTRL0, 8'(s << 4));
         wr(STM_ADDR_CTRL0, 8'((s << 4) | 8));
         repeat (1600) @(posedge clk_i);
         wr(STM_ADDR_CTRL0, 8'((s << 4) | 8'h88));
         rd_cnt();
         chk("source rate", 16'(({hi, lo} >= 1600 / div[s] - 1600 / div[s] / 16 - 2) &&
             ({hi, lo} <= 1600 / div[s] + 1600 / div[s] / 16 + 4)), 16'h0001);
      end
      // pin actions on a full sixteen bit A match at 4: seven compare-mode cases, the last one pwm held active
      wr(STM_ADDR_CMPAL, 8'h04);
      for (int i = 0; i < 8; i++) begin
         wr(STM_ADDR_CTRL0, 8'h60);
         wr(STM_ADDR_CTRL1, cfg[i]);
         wr(STM_ADDR_CTRL0, 8'h68);
         pulse(3);
         chk("pin before", pin_o, pb[i]);
         // the match lands on the tick that leaves the compare value, so two more
         pulse(2);
         chk("pin after", pin_o, pa[i]);
         chk("pin oe", pin_oe_o, 1'b1);
         rdb(STM_ADDR_FLAGS, rd);
         chk("flag a", rd, 8'h01);
         wr(STM_ADDR_FLAGS, 8'h01);
         rdb(STM_ADDR_FLAGS, rd);
         chk("flag a clear", rd, 8'h00);
      end
      // top byte compare P clears the count, compare A off
      wr(STM_ADDR_CTRL0, 8'h60);
      wr(STM_ADDR_CMPAL, 8'h00);
      wr(STM_ADDR_CMPP, 8'h01);
      wr(STM_ADDR_CTRL1, 8'hC0);
      wr(STM_ADDR_CTRL0, 8'h68);
      pulse(255);
      rdb(STM_ADDR_FLAGS, rd);
      chk("flag p early", rd, 8'h00);
      pulse(345);
      rdb(STM_ADDR_FLAGS, rd);
      chk("flag p", rd, 8'h02);
      rd_cnt();
      chk("count after p", {hi, lo}, 16'h0058);
      wr(STM_ADDR_FLAGS, 8'h02);
      rdb(STM_ADDR_FLAGS, rd);
      chk("flag p clear", rd, 8'h00);
      tally_and_finish();
   end
endmodule : stm_timer_tb_top
